/* File: logic/power_table_pkg.sv */
package power_table_pkg;

  localparam int unsigned    ENTRY_W       = 8;
  localparam int unsigned    NUM_ENTRIES   = 2;
  localparam logic [7:0]     DEFAULT_LEVEL = 8'hc6;
  localparam logic [7:0]     FORBID_LO     = 8'h61;
  localparam logic [7:0]     FORBID_HI     = 8'h6f;

  // Power sequencing states
  typedef enum logic [2:0] {
    PWR_ON      = 3'b001,
    PWR_PENDING = 3'b010,
    PWR_OFF     = 3'b100
  } pwr_state_t;

  // Host-side table write request
  typedef struct packed {
    logic               burst;
    logic               index;
    logic [ENTRY_W-1:0] data;
  } table_wr_t;

  // All module state
  typedef struct packed {
    logic [ENTRY_W-1:0] entry1;
    logic [ENTRY_W-1:0] entry0;
    pwr_state_t         pwr;
    logic [ENTRY_W-1:0] pa_level;
    logic               bad_write;
  } table_state_t;

endpackage : power_table_pkg

/* File: logic/tx_power_level_table.sv */
`timescale 1ns/1ps
module tx_power_level_table (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       wr_valid,
  input  wire power_table_pkg::table_wr_t wr_req,
  input  wire logic                       power_table_index,
  input  wire logic                       ook_mode,
  input  wire logic                       tx_symbol,
  input  wire logic                       power_down_strobe,
  input  wire logic                       chip_select_low,
  output logic [7:0]                      pa_level,
  output logic [7:0]                      entry0_level,
  output logic [7:0]                      entry1_level,
  output logic                            core_power_on,
  output logic                            xosc_enable,
  output logic                            bad_write
);

  power_table_pkg::table_state_t s_q;
  power_table_pkg::table_state_t s_d;
  logic                          wr_ok;
  logic                          code_ok;
  logic                          reach_ok;
  logic                          sel;
  logic                          to_sleep;
  logic                          powered;

  // Codes inside the forbidden band never reach the table
  assign code_ok = !(wr_req.data >= power_table_pkg::FORBID_LO &&
                     wr_req.data <= power_table_pkg::FORBID_HI);

  // Single-byte access reaches entry 0 only
  assign reach_ok = wr_req.burst || !wr_req.index;

  // Refused here as well, so a careless host cannot corrupt the table
  assign wr_ok = wr_valid && reach_ok && code_ok;

  // OOK with index 1 lets the symbol pick the entry; otherwise the index alone
  assign sel = (ook_mode && power_table_index) ? tx_symbol : power_table_index;

  // Pending power-down completes once the host releases chip select
  assign to_sleep = (s_q.pwr == power_table_pkg::PWR_PENDING) && !chip_select_low;

  // Core stays up while pending; writes are ignored only when off
  assign powered = (s_q.pwr != power_table_pkg::PWR_OFF);

  // Next state: writes, sleep sequencing, amplifier level
  always_comb begin
    s_d           = s_q;
    s_d.bad_write = wr_valid && !wr_ok;
    if (wr_ok && powered) begin
      if (wr_req.index) begin
        s_d.entry1 = wr_req.data;
      end else begin
        s_d.entry0 = wr_req.data;
      end
    end
    // Power sequencing: on, pending release of chip select, off
    unique case (s_q.pwr)
      power_table_pkg::PWR_ON: begin
        if (power_down_strobe) begin
          s_d.pwr = power_table_pkg::PWR_PENDING;
        end
      end
      power_table_pkg::PWR_PENDING: begin
        // Power holds until the host releases chip select
        if (to_sleep) begin
          s_d.pwr    = power_table_pkg::PWR_OFF;
          s_d.entry1 = '0;
        end
      end
      power_table_pkg::PWR_OFF: begin
        if (chip_select_low) begin
          s_d.pwr = power_table_pkg::PWR_ON;
        end
      end
      default: s_d.pwr = power_table_pkg::PWR_ON;
    endcase
    // Level follows index and symbol one cycle later
    s_d.pa_level = sel ? s_d.entry1 : s_d.entry0;
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q.entry0    <= power_table_pkg::DEFAULT_LEVEL;
      s_q.entry1    <= power_table_pkg::DEFAULT_LEVEL;
      s_q.pwr       <= power_table_pkg::PWR_ON;
      s_q.pa_level  <= power_table_pkg::DEFAULT_LEVEL;
      s_q.bad_write <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pa_level      = s_q.pa_level;
  assign entry0_level  = s_q.entry0;
  assign entry1_level  = s_q.entry1;
  assign core_power_on = powered;
  assign xosc_enable   = core_power_on;
  assign bad_write     = s_q.bad_write;

  // Checks
  // Reset loads the default code everywhere and leaves the core powered
  property p_default;
    @(posedge clk) sys_rst |=>
      entry0_level == power_table_pkg::DEFAULT_LEVEL &&
      entry1_level == power_table_pkg::DEFAULT_LEVEL &&
      pa_level == power_table_pkg::DEFAULT_LEVEL &&
      core_power_on && !bad_write;
  endproperty
  a_default: assert property (p_default) else $error("default level wrong");

  // Strobe alone never cuts power while the host still selects
  property p_hold_power;
    @(posedge clk) disable iff (sys_rst)
      (s_q.pwr == power_table_pkg::PWR_PENDING && chip_select_low) |=> core_power_on;
  endproperty
  a_hold_power: assert property (p_hold_power) else $error("power dropped early");

  // Release of chip select completes the pending power-down
  property p_off;
    @(posedge clk) disable iff (sys_rst)
      (s_q.pwr == power_table_pkg::PWR_PENDING && !chip_select_low) |=> !core_power_on;
  endproperty
  a_off: assert property (p_off) else $error("power not removed");

  // Selecting a sleeping device wakes core and oscillator
  property p_wake;
    @(posedge clk) disable iff (sys_rst)
      (!core_power_on && chip_select_low) |=> core_power_on && xosc_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on select");

  // Entry 0 survives sleep, entry 1 is discarded
  property p_sleep_keep;
    @(posedge clk) disable iff (sys_rst)
      (s_q.pwr == power_table_pkg::PWR_PENDING && !chip_select_low && !wr_valid)
      |=> entry1_level == '0 && entry0_level == $past(entry0_level);
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) else $error("sleep table wrong");

  // Forbidden codes are flagged and never stored
  property p_forbid;
    @(posedge clk) disable iff (sys_rst)
      (wr_valid && wr_req.data >= power_table_pkg::FORBID_LO &&
       wr_req.data <= power_table_pkg::FORBID_HI)
      |=> bad_write && entry0_level == $past(entry0_level);
  endproperty
  a_forbid: assert property (p_forbid) else $error("forbidden code stored");

  // Single-byte access to entry 1 leaves it alone; sleep may still clear it
  property p_single;
    @(posedge clk) disable iff (sys_rst)
      (wr_valid && !wr_req.burst && wr_req.index && !to_sleep)
      |=> entry1_level == $past(entry1_level);
  endproperty
  a_single: assert property (p_single) else $error("single write hit entry 1");

  // OOK with index 1: the symbol chooses the entry
  property p_ook;
    @(posedge clk) disable iff (sys_rst)
      (ook_mode && power_table_index && !wr_valid && core_power_on && !power_down_strobe)
      |=> pa_level == ($past(tx_symbol) ? entry1_level : entry0_level);
  endproperty
  a_ook: assert property (p_ook) else $error("ook level wrong");

  // Other formats: the index alone chooses the entry
  property p_sel;
    @(posedge clk) disable iff (sys_rst)
      (!ook_mode && !wr_valid && core_power_on && !power_down_strobe)
      |=> pa_level == ($past(power_table_index) ? entry1_level : entry0_level);
  endproperty
  a_sel: assert property (p_sel) else $error("selected level wrong");

  // Accepted single-byte write lands in entry 0 one cycle later
  property p_write0;
    @(posedge clk) disable iff (sys_rst)
      (wr_valid && !wr_req.index && code_ok && powered)
      |=> entry0_level == $past(wr_req.data);
  endproperty
  a_write0: assert property (p_write0) else $error("entry 0 write lost");

  // Accepted burst write lands in entry 1 unless sleep clears it
  property p_write1;
    @(posedge clk) disable iff (sys_rst)
      (wr_valid && wr_req.burst && wr_req.index && code_ok && powered && !to_sleep)
      |=> entry1_level == $past(wr_req.data);
  endproperty
  a_write1: assert property (p_write1) else $error("entry 1 write lost");

  // Writes while unpowered leave the table untouched
  property p_off_write;
    @(posedge clk) disable iff (sys_rst)
      (!powered && wr_valid)
      |=> entry0_level == $past(entry0_level) && entry1_level == $past(entry1_level);
  endproperty
  a_off_write: assert property (p_off_write) else $error("write while off");

  // Strobe moves a powered core to pending, power still on
  property p_strobe;
    @(posedge clk) disable iff (sys_rst)
      (s_q.pwr == power_table_pkg::PWR_ON && power_down_strobe)
      |=> s_q.pwr == power_table_pkg::PWR_PENDING && core_power_on;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not taken");

  // Power state stays one-hot
  property p_onehot;
    @(posedge clk) disable iff (sys_rst) $onehot(s_q.pwr);
  endproperty
  a_onehot: assert property (p_onehot) else $error("power state corrupt");

  // Oscillator runs exactly while the core is powered
  property p_xosc;
    @(posedge clk) disable iff (sys_rst) xosc_enable == core_power_on;
  endproperty
  a_xosc: assert property (p_xosc) else $error("oscillator out of step");

  // Main scenarios
  c_ook: cover property (@(posedge clk) ook_mode && power_table_index && tx_symbol);
  c_sleep: cover property (@(posedge clk) s_q.pwr == power_table_pkg::PWR_OFF);
  c_burst: cover property (@(posedge clk) wr_valid && wr_req.burst && wr_req.index);
  c_bad: cover property (@(posedge clk) bad_write);
  c_wake: cover property (@(posedge clk) !core_power_on ##1 core_power_on);

endmodule : tx_power_level_table

/* File: verif/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input  wire logic                  clk,
  output logic                       wr_valid,
  output power_table_pkg::table_wr_t wr_req,
  output logic                       power_down_strobe,
  output logic                       chip_select_low
);
  // Idle host keeps the device selected
  initial begin
    wr_valid = 1'b0;
    wr_req = '0;
    power_down_strobe = 1'b0;
    chip_select_low = 1'b1;
  end
  // One write pulse; entry 1 needs the burst flag
  task automatic put(input logic idx, input logic [7:0] code, input logic burst);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_req <= '{burst, idx, code};
    @(posedge clk);
    wr_valid <= 1'b0;
  endtask : put
  // Strobe with select still held, so power must stay up
  task automatic sleep();
    @(posedge clk);
    power_down_strobe <= 1'b1;
    @(posedge clk);
    power_down_strobe <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : sleep
  task automatic sel_cs(input logic v);
    @(posedge clk);
    chip_select_low <= v;
  endtask : sel_cs
endmodule : host_model

/* File: verif/tx_power_level_table_tb.sv */
`timescale 1ns/1ps
module tx_power_level_table_tb;
  logic                       clk = 1'b0;
  logic                       sys_rst = 1'b1;
  logic                       power_table_index = 1'b0;
  logic                       ook_mode = 1'b0;
  logic                       tx_symbol = 1'b0;
  logic                       wr_valid, power_down_strobe, chip_select_low;
  power_table_pkg::table_wr_t wr_req;
  logic [7:0]                 pa_level, entry0_level, entry1_level;
  logic                       core_power_on, xosc_enable, bad_write;
  int                         errors = 0;
  int                         comparisons = 0;
  int                         refusals = 0;
  always #50 clk = ~clk;
  tx_power_level_table i_tx_power_level_table (.clk, .sys_rst, .wr_valid, .wr_req,
    .power_table_index, .ook_mode, .tx_symbol, .power_down_strobe, .chip_select_low,
    .pa_level, .entry0_level, .entry1_level, .core_power_on, .xosc_enable, .bad_write);
  host_model i_host_model (.clk, .wr_valid, .wr_req, .power_down_strobe, .chip_select_low);
  // Count refusal pulses; they last only one cycle
  always @(posedge clk) begin
    if (bad_write === 1'b1) refusals++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Land on a falling edge so registered outputs have settled
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wait_n
  task automatic sel(input logic idx, input logic ook, input logic sym);
    @(posedge clk);
    power_table_index <= idx;
    ook_mode <= ook;
    tx_symbol <= sym;
    wait_n(1);
  endtask : sel
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // Hang guard
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    wait_n(1);
    chk(entry0_level, 8'hc6);
    chk(entry1_level, 8'hc6);
    chk(pa_level, 8'hc6);
    $display("Reset test done");
    i_host_model.put(1'b0, 8'h50, 1'b0);
    i_host_model.put(1'b1, 8'h03, 1'b1);
    sel(1'b1, 1'b0, 1'b0);
    chk(pa_level, 8'h03);
    sel(1'b0, 1'b0, 1'b1);
    chk(pa_level, 8'h50);
    sel(1'b1, 1'b1, 1'b0);
    chk(pa_level, 8'h50);
    sel(1'b0, 1'b1, 1'b1);
    chk(pa_level, 8'h50);
    sel(1'b1, 1'b1, 1'b1);
    chk(pa_level, 8'h03);
    $display("Selection test done");
    // Bad writes first, then the codes just outside the forbidden range
    i_host_model.put(1'b1, 8'h27, 1'b0);
    i_host_model.put(1'b0, 8'h61, 1'b0);
    i_host_model.put(1'b1, 8'h6f, 1'b1);
    i_host_model.put(1'b0, 8'h60, 1'b0);
    i_host_model.put(1'b1, 8'h70, 1'b1);
    wait_n(2);
    chk(8'(refusals), 8'h03);
    chk(entry0_level, 8'h60);
    chk(entry1_level, 8'h70);
    $display("Refusal test done");
    i_host_model.sleep();
    wait_n(0);
    chk({7'h00, core_power_on}, 8'h01);
    i_host_model.sel_cs(1'b0);
    wait_n(3);
    chk({7'h00, core_power_on}, 8'h00);
    chk(entry0_level, 8'h60);
    chk(entry1_level, 8'h00);
    chk(pa_level, 8'h00);
    // Writes while off must be ignored
    i_host_model.put(1'b0, 8'h11, 1'b0);
    wait_n(1);
    chk(entry0_level, 8'h60);
    i_host_model.sel_cs(1'b1);
    wait_n(2);
    chk({6'h00, core_power_on, xosc_enable}, 8'h03);
    $display("Sleep test done");
    // Second reset in mid-run restores the defaults
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wait_n(1);
    chk(entry1_level, 8'hc6);
    chk(pa_level, 8'hc6);
    $display("Second reset test done");
    finish_test();
  end
endmodule : tx_power_level_table_tb
